// ==== hw/dbfi_bank.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbfi_defines.svh"

module dbfi_bank
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Request events and register commands
  input wire logic [`DBFI_BANK_W-1:0] fallEv,
  input wire dbfi_pkg::dbfi_cmd_t cmd,
  // Register contents and interrupt line
  output logic [`DBFI_BANK_W-1:0] maskQ,
  output logic [`DBFI_BANK_W-1:0] pendQ,
  output logic [`DBFI_BANK_W-1:0] statQ,
  output logic [`DBFI_VEC_W-1:0] vecQ,
  output logic frozenQ,
  output logic irqN
);
  import dbfi_pkg::*;

  dbfi_bank_t st_q;
  dbfi_bank_t st_d;
  logic [`DBFI_BANK_W-1:0] pendIn;
  logic [`DBFI_BANK_W-1:0] statIn;
  logic [`DBFI_BANK_W-1:0] wMasked;

  // Highest set bit wins
  function automatic logic [`DBFI_VEC_W-1:0] vec_of(
    input logic [`DBFI_BANK_W-1:0] s);
    logic [`DBFI_VEC_W-1:0] v;
    v = `DBFI_VEC_NONE;
    for (int i = 0; i < `DBFI_BANK_W; i++)
    begin
      if (s[i])
        v = `DBFI_VEC_W'(i);
    end
    return v;
  endfunction

  always_comb
  begin
    st_d = st_q;
    wMasked = cmd.wdata & cmd.byteMask;
    pendIn = st_q.pend;
    if (cmd.wrPend)
      pendIn = (st_q.pend & ~cmd.byteMask) | wMasked;
    pendIn = pendIn | fallEv;
    statIn = st_q.stat;
    if (cmd.wrStat)
      statIn = statIn & ~wMasked;
    if (cmd.rdVec && st_q.vec != `DBFI_VEC_NONE)
      statIn[st_q.vec[3:0]] = 1'b0;
    if (!st_q.frozen)
    begin
      st_d.stat = statIn | (pendIn & st_q.mask);
      st_d.pend = `DBFI_RST_WORD;
    end
    else
    begin
      st_d.stat = statIn;
      st_d.pend = pendIn;
    end
    if (cmd.wrMask)
      st_d.mask = (st_q.mask & ~cmd.byteMask) | wMasked;
    if (cmd.wrVec)
      st_d.frozen = 1'b0;
    if (cmd.rdVec || cmd.rdStat)
      st_d.frozen = 1'b1;
    st_d.vec = vec_of(st_d.stat);
    st_d.irqOn = (|st_d.stat) && !st_d.frozen;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_q <= '0;
      st_q.vec <= `DBFI_VEC_NONE;
    end
    else
      st_q <= st_d;
  end

  assign maskQ = st_q.mask;
  assign pendQ = st_q.pend;
  assign statQ = st_q.stat;
  assign vecQ = st_q.vec;
  assign frozenQ = st_q.frozen;
  assign irqN = ~st_q.irqOn;

endmodule
`default_nettype wire

// ==== hw/dbfi_defines.svh ====
`ifndef DBFI_DEFINES_SVH
`define DBFI_DEFINES_SVH

// Bank geometry
`define DBFI_BANK_W 16
`define DBFI_EXT_N 4
`define DBFI_INTB_W 12
`define DBFI_ADDR_W 6

// Register map: bank select bit, register index field, extra register
`define DBFI_BANK_BIT 4
`define DBFI_REG_MASK 2'h0
`define DBFI_REG_PEND 2'h1
`define DBFI_REG_STAT 2'h2
`define DBFI_REG_VEC 2'h3
`define DBFI_OFF_FRZ 6'h20

// Vector encoding and reset values
`define DBFI_VEC_W 8
`define DBFI_VEC_NONE 8'hFF
`define DBFI_RST_WORD 16'h0000

// Bus answers
`define DBFI_RESP_OKAY 2'h0
`define DBFI_RESP_SLVERR 2'h2

`endif

// ==== hw/dbfi_pkg.sv ====
`default_nettype none
`include "dbfi_defines.svh"

package dbfi_pkg;

  typedef struct packed {
    logic wrMask;
    logic wrPend;
    logic wrStat;
    logic wrVec;
    logic rdStat;
    logic rdVec;
    logic [`DBFI_BANK_W-1:0] byteMask;
    logic [`DBFI_BANK_W-1:0] wdata;
  } dbfi_cmd_t;

  typedef struct packed {
    logic frozen;
    logic irqOn;
    logic [`DBFI_BANK_W-1:0] mask;
    logic [`DBFI_BANK_W-1:0] pend;
    logic [`DBFI_BANK_W-1:0] stat;
    logic [`DBFI_VEC_W-1:0] vec;
  } dbfi_bank_t;

  typedef struct packed {
    logic awHeld;
    logic [`DBFI_ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [1:0] rResp;
    logic [31:0] rData;
    logic [`DBFI_EXT_N-1:0] extS1;
    logic [`DBFI_EXT_N-1:0] extS2;
    logic [`DBFI_EXT_N-1:0] extPrev;
    logic [`DBFI_BANK_W-1:0] intPrevA;
    logic [`DBFI_INTB_W-1:0] intPrevB;
  } dbfi_top_t;

endpackage
`default_nettype wire

// ==== hw/dbfi_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbfi_defines.svh"

module dbfi_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`DBFI_ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`DBFI_ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Internal unit requests, active low, same clock
  input wire logic [`DBFI_BANK_W-1:0] intReqAN,
  input wire logic [`DBFI_INTB_W-1:0] intReqBN,
  // External request pins
  input wire logic [`DBFI_EXT_N-1:0] ext_irq_in_n,
  // Interrupt outputs
  output logic irq_out_bank_a_n,
  output logic irq_out_bank_b_n
);
  import dbfi_pkg::*;

  dbfi_top_t q_q;
  dbfi_top_t q_d;
  dbfi_cmd_t cmdA;
  dbfi_cmd_t cmdB;
  logic [`DBFI_BANK_W-1:0] fallA;
  logic [`DBFI_BANK_W-1:0] fallB;
  logic [`DBFI_BANK_W-1:0] maskA;
  logic [`DBFI_BANK_W-1:0] pendA;
  logic [`DBFI_BANK_W-1:0] statA;
  logic [`DBFI_VEC_W-1:0] vecA;
  logic frozenA;
  logic [`DBFI_BANK_W-1:0] maskB;
  logic [`DBFI_BANK_W-1:0] pendB;
  logic [`DBFI_BANK_W-1:0] statB;
  logic [`DBFI_VEC_W-1:0] vecB;
  logic frozenB;
  logic doWrite;
  logic doRead;
  logic wrBankSel;
  logic rdBankSel;
  logic wrMapped;
  logic rdMapped;
  logic rdFrz;
  logic [1:0] wrIdx;
  logic [1:0] rdIdx;
  logic [`DBFI_BANK_W-1:0] wrLanes;
  logic [`DBFI_BANK_W-1:0] rdWord;

  // Handshake outputs
  assign s_axi_awready = !q_q.awHeld;
  assign s_axi_wready = !q_q.wHeld;
  assign s_axi_arready = !q_q.rValid;
  assign s_axi_bvalid = q_q.bValid;
  assign s_axi_bresp = q_q.bResp;
  assign s_axi_rvalid = q_q.rValid;
  assign s_axi_rdata = q_q.rData;
  assign s_axi_rresp = q_q.rResp;

  // Request edges: internal lines need one stage, pins need two more
  assign fallA = q_q.intPrevA & ~intReqAN;
  assign fallB = {q_q.intPrevB & ~intReqBN,
    q_q.extPrev & ~q_q.extS2};

  // Access decode
  assign doWrite = q_q.awHeld && q_q.wHeld && !q_q.bValid;
  assign doRead = s_axi_arvalid && !q_q.rValid;
  assign wrBankSel = q_q.awAddr[`DBFI_BANK_BIT];
  assign rdBankSel = s_axi_araddr[`DBFI_BANK_BIT];
  assign wrIdx = q_q.awAddr[3:2];
  assign rdIdx = s_axi_araddr[3:2];
  assign wrMapped = !q_q.awAddr[5];
  assign rdFrz = {s_axi_araddr[5:2], 2'h0} == `DBFI_OFF_FRZ;
  assign rdMapped = !s_axi_araddr[5] || rdFrz;
  assign wrLanes = {{8{q_q.wStrb[1]}}, {8{q_q.wStrb[0]}}};

  always_comb
  begin
    cmdA = '0;
    cmdA.byteMask = wrLanes;
    cmdA.wdata = q_q.wData[`DBFI_BANK_W-1:0];
    cmdB = cmdA;
    if (doWrite && wrMapped)
    begin
      if (!wrBankSel)
      begin
        cmdA.wrMask = wrIdx == `DBFI_REG_MASK;
        cmdA.wrPend = wrIdx == `DBFI_REG_PEND;
        cmdA.wrStat = wrIdx == `DBFI_REG_STAT;
        cmdA.wrVec = wrIdx == `DBFI_REG_VEC;
      end
      else
      begin
        cmdB.wrMask = wrIdx == `DBFI_REG_MASK;
        cmdB.wrPend = wrIdx == `DBFI_REG_PEND;
        cmdB.wrStat = wrIdx == `DBFI_REG_STAT;
        cmdB.wrVec = wrIdx == `DBFI_REG_VEC;
      end
    end
    if (doRead && !s_axi_araddr[5])
    begin
      if (!rdBankSel)
      begin
        cmdA.rdStat = rdIdx == `DBFI_REG_STAT;
        cmdA.rdVec = rdIdx == `DBFI_REG_VEC;
      end
      else
      begin
        cmdB.rdStat = rdIdx == `DBFI_REG_STAT;
        cmdB.rdVec = rdIdx == `DBFI_REG_VEC;
      end
    end
  end

  // Read data selection
  always_comb
  begin
    rdWord = `DBFI_RST_WORD;
    if (rdFrz)
      rdWord = {14'h0000, frozenB, frozenA};
    else
    begin
      unique case (rdIdx)
        `DBFI_REG_MASK: rdWord = rdBankSel ? maskB : maskA;
        `DBFI_REG_PEND: rdWord = rdBankSel ? pendB : pendA;
        `DBFI_REG_STAT: rdWord = rdBankSel ? statB : statA;
        `DBFI_REG_VEC: rdWord = {8'h00, rdBankSel ? vecB : vecA};
      endcase
    end
  end

  always_comb
  begin
    q_d = q_q;
    q_d.extS1 = ext_irq_in_n;
    q_d.extS2 = q_q.extS1;
    q_d.extPrev = q_q.extS2;
    q_d.intPrevA = intReqAN;
    q_d.intPrevB = intReqBN;
    if (s_axi_awvalid && !q_q.awHeld)
    begin
      q_d.awHeld = 1'b1;
      q_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q_q.wHeld)
    begin
      q_d.wHeld = 1'b1;
      q_d.wData = s_axi_wdata;
      q_d.wStrb = s_axi_wstrb;
    end
    if (q_q.bValid && s_axi_bready)
      q_d.bValid = 1'b0;
    if (doWrite)
    begin
      q_d.awHeld = 1'b0;
      q_d.wHeld = 1'b0;
      q_d.bValid = 1'b1;
      q_d.bResp = wrMapped ? `DBFI_RESP_OKAY : `DBFI_RESP_SLVERR;
    end
    if (q_q.rValid && s_axi_rready)
      q_d.rValid = 1'b0;
    if (doRead)
    begin
      q_d.rValid = 1'b1;
      q_d.rResp = rdMapped ? `DBFI_RESP_OKAY : `DBFI_RESP_SLVERR;
      q_d.rData = rdMapped ? {16'h0000, rdWord} : 32'h00000000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      q_q <= '0;
    else
      q_q <= q_d;
  end

  // Two independent banks
  dbfi_bank u_bank_a
  (
    .clk(clk),
    .nrst(nrst),
    .fallEv(fallA),
    .cmd(cmdA),
    .maskQ(maskA),
    .pendQ(pendA),
    .statQ(statA),
    .vecQ(vecA),
    .frozenQ(frozenA),
    .irqN(irq_out_bank_a_n)
  );

  dbfi_bank u_bank_b
  (
    .clk(clk),
    .nrst(nrst),
    .fallEv(fallB),
    .cmd(cmdB),
    .maskQ(maskB),
    .pendQ(pendB),
    .statQ(statB),
    .vecQ(vecB),
    .frozenQ(frozenB),
    .irqN(irq_out_bank_b_n)
  );

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic intPrevAOne;
  assign intPrevAOne = q_q.intPrevA[0] && !intReqAN[0];
  property p_fall_sets;
    intPrevAOne && frozenA && !cmdA.wrPend && !cmdA.wrVec
      |=> pendA[0];
  endproperty
  a_fall_sets: assert property (p_fall_sets)
    else $error("falling request did not set pending bit");

  property p_ext_edge;
    $fell(q_q.extS2[0]) |-> fallB[0] ##1 !fallB[0];
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("external edge not seen exactly once");

  property p_transfer;
    !frozenA |=> pendA == 16'h0000;
  endproperty
  a_transfer: assert property (p_transfer)
    else $error("pending not drained while released");

  property p_masked;
    1'b1 |=> ((statA & ~$past(statA)) & ~$past(maskA)) == 16'h0000;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked request reached status");

  property p_irq_low;
    $rose(|statA) && !frozenA |-> !irq_out_bank_a_n
      && vecA != `DBFI_VEC_NONE;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("status set without interrupt or vector");

  property p_read_freeze;
    cmdA.rdStat || cmdA.rdVec |=> frozenA && irq_out_bank_a_n
      ##1 (frozenA || $past(cmdA.wrVec));
  endproperty
  a_read_freeze: assert property (p_read_freeze)
    else $error("read did not freeze bank");

  property p_vec_clear;
    cmdA.rdVec && frozenA && vecA != `DBFI_VEC_NONE
      |=> !statA[$past(vecA[3:0])];
  endproperty
  a_vec_clear: assert property (p_vec_clear)
    else $error("vector read left its status bit set");

  property p_stat_write;
    cmdA.wrStat && !cmdA.rdStat && !cmdA.rdVec && !cmdA.wrVec
      |=> frozenA == $past(frozenA);
  endproperty
  a_stat_write: assert property (p_stat_write)
    else $error("status write changed frozen state");

  property p_release;
    cmdA.wrVec && !cmdA.rdStat && !cmdA.rdVec |=> !frozenA;
  endproperty
  a_release: assert property (p_release)
    else $error("vector write did not release bank");

  property p_priority;
    vecA != `DBFI_VEC_NONE |-> (statA >> vecA[3:0]) == 16'h0001;
  endproperty
  a_priority: assert property (p_priority)
    else $error("vector is not the highest set status bit");

  property p_indep;
    cmdB.rdVec && !frozenA && !cmdA.rdStat && !cmdA.rdVec |=> !frozenA;
  endproperty
  a_indep: assert property (p_indep)
    else $error("bank B read froze bank A");

  property p_bresp;
    doWrite |=> s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing");

  c_vec_read: cover property (cmdA.rdVec && vecA != `DBFI_VEC_NONE);
  c_rearm: cover property (cmdA.wrVec ##[1:4] !irq_out_bank_a_n);
  c_masked: cover property (fallA[0] && !maskA[0] && !frozenA);
  c_pin_event: cover property (fallB[0] && maskB[0] && !frozenB);
  c_frozen_merge: cover property (fallA[5] && frozenA && pendA[5]);

  property p_irq_b;
    $rose(|statB) && !frozenB |-> !irq_out_bank_b_n;
  endproperty
  a_irq_b: assert property (p_irq_b)
    else $error("bank B status set without interrupt");

endmodule
`default_nettype wire

// ==== test/dbfi_host.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbfi_defines.svh"

module dbfi_host
(
  // Clock
  input wire logic clk,
  // Write channels
  output logic awvalid,
  input wire logic awready,
  output logic [`DBFI_ADDR_W-1:0] awaddr,
  output logic wvalid,
  input wire logic wready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  input wire logic bvalid,
  output logic bready,
  input wire logic [1:0] bresp,
  // Read channels
  output logic arvalid,
  input wire logic arready,
  output logic [`DBFI_ADDR_W-1:0] araddr,
  input wire logic rvalid,
  output logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp
);
  initial
  begin
    awvalid = 1'h0;
    awaddr = '0;
    wvalid = 1'h0;
    wdata = '0;
    wstrb = '0;
    bready = 1'h0;
    arvalid = 1'h0;
    araddr = '0;
    rready = 1'h0;
  end

  // One write; released address and data lines show the inverse of their last value, wstrb keeps it
  task automatic wr(input logic [`DBFI_ADDR_W-1:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
      begin
        awvalid <= 1'h0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'h0;
        wdata <= ~d;
      end
    end
    while (!(bvalid && bready));
    r = bresp;
    bready <= 1'h0;
  endtask

  // One read
  task automatic rd(input logic [`DBFI_ADDR_W-1:0] a,
    output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
      begin
        arvalid <= 1'h0;
        araddr <= ~a;
      end
    end
    while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "dbfi_defines.svh"

module tb;
  import dbfi_pkg::*;
  logic clk;
  logic nrst;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [`DBFI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] intReqAN;
  logic [11:0] intReqBN;
  logic [3:0] extIrqN;
  logic irqAN, irqBN;
  logic [15:0] mMask [2];
  logic [15:0] mPend [2];
  logic [15:0] mStat [2];
  logic mFrz [2];
  int nErrors;
  int nTests;

  dbfi_top dut_u (.clk(clk), .nrst(nrst), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .intReqAN(intReqAN), .intReqBN(intReqBN),
    .ext_irq_in_n(extIrqN), .irq_out_bank_a_n(irqAN),
    .irq_out_bank_b_n(irqBN));

  dbfi_host host_u (.clk(clk), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  function automatic logic [5:0] ad(input int b, input int rg);
    return 6'(b * 16 + rg * 4);
  endfunction

  // Highest set bit wins
  function automatic logic [7:0] vecOf(input logic [15:0] s);
    for (int i = 15; i >= 0; i--)
      if (s[i])
        return 8'(i);
    return `DBFI_VEC_NONE;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic endSim();
    if (nErrors == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic settle();
    repeat (6) @(posedge clk);
    chk({31'h0, irqAN}, {31'h0, !(|mStat[0] && !mFrz[0])});
    chk({31'h0, irqBN}, {31'h0, !(|mStat[1] && !mFrz[1])});
  endtask

  task automatic wreg(input int b, input int rg, input logic [15:0] v,
    input logic [3:0] s);
    logic [1:0] r;
    logic [15:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    host_u.wr(ad(b, rg), {~v, v}, s, r);
    chk(32'(r), 32'(`DBFI_RESP_OKAY));
    if (rg == 0)
      mMask[b] = (mMask[b] & ~m) | (v & m);
    else if (rg == 1)
      mPend[b] = (mPend[b] & ~m) | (v & m);
    else if (rg == 2)
      mStat[b] = mStat[b] & ~(v & m);
    else
      mFrz[b] = 1'h0;
    if (!mFrz[b])
    begin
      mStat[b] = mStat[b] | (mPend[b] & mMask[b]);
      mPend[b] = '0;
    end
    settle();
  endtask

  task automatic rreg(input int b, input int rg);
    logic [1:0] r;
    logic [31:0] d;
    logic [15:0] e;
    host_u.rd(ad(b, rg), d, r);
    e = rg == 0 ? mMask[b] : rg == 1 ? mPend[b] : rg == 2 ? mStat[b]
      : 16'(vecOf(mStat[b]));
    chk(d, {16'h0000, e});
    chk(32'(r), 32'(`DBFI_RESP_OKAY));
    if (rg == 3 && mStat[b] != 0)
      mStat[b][vecOf(mStat[b])] = 1'h0;
    if (rg >= 2)
      mFrz[b] = 1'h1;
    settle();
  endtask

  task automatic rfrz();
    logic [1:0] r;
    logic [31:0] d;
    host_u.rd(`DBFI_OFF_FRZ, d, r);
    chk(d, {30'h0, mFrz[1], mFrz[0]});
    chk(32'(r), 32'(`DBFI_RESP_OKAY));
  endtask

  // Falling edges on the lines of one bank; bank B bits 3:0 are pins
  task automatic evm(input int b, input logic [15:0] k);
    if (b == 0)
      intReqAN <= ~k;
    else
    begin
      intReqBN <= ~k[15:4];
      extIrqN <= ~k[3:0];
    end
    repeat (2) @(posedge clk);
    intReqAN <= '1;
    intReqBN <= '1;
    extIrqN <= '1;
    for (int i = 0; i < 16; i++)
      if (k[i] && mFrz[b])
        mPend[b][i] = 1'h1;
      else if (k[i] && mMask[b][i])
        mStat[b][i] = 1'h1;
    settle();
  endtask

  initial
  begin
    repeat (40000) @(posedge clk);
    nErrors++;
    endSim();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int b;
    nErrors = 0;
    nTests = 0;
    nrst = 1'h0;
    intReqAN = '1;
    intReqBN = '1;
    extIrqN = '1;
    for (int i = 0; i < 2; i++)
    begin
      mMask[i] = '0;
      mPend[i] = '0;
      mStat[i] = '0;
      mFrz[i] = 1'h0;
    end
    void'($urandom(32'h29FB));
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rfrz();
    for (int i = 0; i < 8; i++)
      rreg(i / 4, i % 4);
    rfrz();
    host_u.rd(6'h24, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(`DBFI_RESP_SLVERR));
    host_u.wr(6'h3C, 32'hFFFF, 4'hF, r);
    chk(32'(r), 32'(`DBFI_RESP_SLVERR));
    wreg(0, 3, 16'h0000, 4'hF);
    wreg(1, 3, 16'hFFFF, 4'hF);
    wreg(0, 0, 16'hFFFF, 4'h3);
    wreg(1, 0, 16'h000F, 4'h3);
    rreg(0, 2);
    evm(0, 16'h0120);
    evm(0, 16'h0020);
    evm(1, 16'h0019);
    rfrz();
    wreg(0, 3, 16'h1234, 4'hF);
    rreg(0, 3);
    evm(0, 16'h8000);
    rreg(0, 3);
    rreg(0, 3);
    rreg(0, 1);
    wreg(0, 3, 16'h0000, 4'hF);
    for (int i = 0; i < 120; i++)
    begin
      b = $urandom_range(1, 0);
      case ($urandom_range(6, 0))
        0, 1, 2: wreg(b, $urandom_range(2, 0), 16'($urandom), 4'($urandom));
        3: wreg(b, 3, 16'($urandom), 4'hF);
        4: evm(b, 16'($urandom) & 16'($urandom));
        5: rreg(b, $urandom_range(3, 0));
        default: rfrz();
      endcase
    end
    endSim();
  end
endmodule
`default_nettype wire
